/* design/pio_port8.sv */
// One 8-bit port slice: output latch, pin drive and readback
`timescale 1ns/1ps
`default_nettype none
module pio_port8
  import pio_pkg::*;
(
  input  wire logic       clock,      // System clock
  input  wire logic       reset,      // Synchronous reset, active high
  input  wire logic       clk_en,     // Freezes state while low
  input  wire logic       clear,      // Clear latch on mode set
  input  wire logic       wr,         // Write strobe for this port
  input  wire logic [7:0] wdata,      // Write data
  input  wire logic [1:0] half_in,    // Per half input select, [1]=upper
  input  wire logic [7:0] pin_in,     // Pin levels
  output logic      [7:0] rd_val,     // Combinational readback value
  output logic      [7:0] pin_out_r,  // Pin drive value
  output logic      [7:0] pin_oe_r    // Pin output enable
);

  logic [7:0] latch_r;
  logic [7:0] in_mask;

  assign in_mask = {{PIO_HALF_W{half_in[1]}}, {PIO_HALF_W{half_in[0]}}};

  always_ff @(posedge clock) begin
    if (reset) begin
      latch_r <= PIO_DATA_RESET;
    end else if (clk_en) begin
      if (clear) begin
        latch_r <= PIO_DATA_RESET;
      end else if (wr) begin
        latch_r <= wdata;
      end
    end
  end

  // Input bits read live pins, output bits read the latch
  assign rd_val = (pin_in & in_mask) | (latch_r & ~in_mask);

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_out_r <= PIO_DATA_RESET;
      pin_oe_r  <= PIO_DATA_RESET;
    end else if (clk_en) begin
      pin_out_r <= latch_r;
      pin_oe_r  <= ~in_mask;
    end
  end

endmodule
`default_nettype wire

/* design/pio_top.sv */
// Top: 24-line parallel I/O port in basic input/output mode
`timescale 1ns/1ps
`default_nettype none
module pio_top
  import pio_pkg::*;
#(
  parameter bit EMULATION = 1'b1   // Variant that offers basic mode only
)
(
  input  wire logic        clock,         // 100 MHz system clock
  input  wire logic        reset,         // Synchronous reset, active high
  input  wire logic        clk_en,        // Clock enable, freezes state when low
  input  wire pio_req_s    host_req,      // Host read/write request
  output logic      [7:0]  host_rdata_r,  // Read data, valid cycle after rd
  output logic             host_rvalid_r, // Read data valid pulse
  input  wire logic [7:0]  port_a_in,     // Port A pin levels
  input  wire logic [7:0]  port_b_in,     // Port B pin levels
  input  wire logic [7:0]  port_c_in,     // Port C pin levels
  output logic      [7:0]  port_a_out_r,  // Port A drive value
  output logic      [7:0]  port_a_oe_r,   // Port A output enable
  output logic      [7:0]  port_b_out_r,  // Port B drive value
  output logic      [7:0]  port_b_oe_r,   // Port B output enable
  output logic      [7:0]  port_c_out_r,  // Port C drive value
  output logic      [7:0]  port_c_oe_r,   // Port C output enable
  output pio_mode_e        grp1_mode_r,   // First group active mode
  output pio_mode_e        grp2_mode_r    // Second group active mode
);

  // ----------------------------------------------------------------
  // Control byte decode
  // ----------------------------------------------------------------
  pio_dir_s   dir_r;
  pio_mode_e  grp1_nxt;
  pio_mode_e  grp2_nxt;
  logic       wr_ctrl;
  logic       mode_set_flag;
  logic       first_group_mode_hi;
  logic       first_group_mode_lo;
  logic       second_group_mode_bit;
  logic       mode_ok;
  logic       apply_ctrl;

  assign wr_ctrl               = host_req.wr && (host_req.addr == PIO_OFS_CTRL);
  assign mode_set_flag         = host_req.wdata[PIO_BIT_MODE_SET];
  assign first_group_mode_hi   = host_req.wdata[PIO_BIT_GRP1_HI];
  assign first_group_mode_lo   = host_req.wdata[PIO_BIT_GRP1_LO];
  assign second_group_mode_bit = host_req.wdata[PIO_BIT_GRP2];

  always_comb begin
    if (first_group_mode_hi) begin
      grp1_nxt = PIO_MODE_BIDIR;
    end else if (first_group_mode_lo) begin
      grp1_nxt = PIO_MODE_STROBED;
    end else begin
      grp1_nxt = PIO_MODE_BASIC;
    end
    grp2_nxt = second_group_mode_bit ? PIO_MODE_STROBED : PIO_MODE_BASIC;
  end

  // Emulation keeps basic only; strobed timing itself is not built either way
  assign mode_ok    = !EMULATION || (grp1_nxt == PIO_MODE_BASIC && grp2_nxt == PIO_MODE_BASIC);
  assign apply_ctrl = wr_ctrl && mode_set_flag && mode_ok;

  always_ff @(posedge clock) begin
    if (reset) begin
      dir_r       <= PIO_DIR_RESET;
      grp1_mode_r <= PIO_MODE_BASIC;
      grp2_mode_r <= PIO_MODE_BASIC;
    end else if (clk_en && apply_ctrl) begin
      dir_r.dir_a          <= host_req.wdata[PIO_BIT_DIR_A];
      dir_r.upper_half_dir <= host_req.wdata[PIO_BIT_DIR_CU];
      dir_r.dir_b          <= host_req.wdata[PIO_BIT_DIR_B];
      dir_r.lower_half_dir <= host_req.wdata[PIO_BIT_DIR_CL];
      grp1_mode_r          <= grp1_nxt;
      grp2_mode_r          <= grp2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Port slices
  // ----------------------------------------------------------------
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic [7:0] rd_c;

  pio_port8 u_port_a (
    .clock     (clock),
    .reset     (reset),
    .clk_en    (clk_en),
    .clear     (apply_ctrl),
    .wr        (host_req.wr && host_req.addr == PIO_OFS_PORT_A),
    .wdata     (host_req.wdata),
    .half_in   ({dir_r.dir_a, dir_r.dir_a}),
    .pin_in    (port_a_in),
    .rd_val    (rd_a),
    .pin_out_r (port_a_out_r),
    .pin_oe_r  (port_a_oe_r)
  );

  pio_port8 u_port_b (
    .clock     (clock),
    .reset     (reset),
    .clk_en    (clk_en),
    .clear     (apply_ctrl),
    .wr        (host_req.wr && host_req.addr == PIO_OFS_PORT_B),
    .wdata     (host_req.wdata),
    .half_in   ({dir_r.dir_b, dir_r.dir_b}),
    .pin_in    (port_b_in),
    .rd_val    (rd_b),
    .pin_out_r (port_b_out_r),
    .pin_oe_r  (port_b_oe_r)
  );

  // Halves steer independently; a write always carries the whole byte
  pio_port8 u_port_c (
    .clock     (clock),
    .reset     (reset),
    .clk_en    (clk_en),
    .clear     (apply_ctrl),
    .wr        (host_req.wr && host_req.addr == PIO_OFS_PORT_C),
    .wdata     (host_req.wdata),
    .half_in   ({dir_r.upper_half_dir, dir_r.lower_half_dir}),
    .pin_in    (port_c_in),
    .rd_val    (rd_c),
    .pin_out_r (port_c_out_r),
    .pin_oe_r  (port_c_oe_r)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;

  always_comb begin
    case (host_req.addr)
      PIO_OFS_PORT_A: rdata_nxt = rd_a;
      PIO_OFS_PORT_B: rdata_nxt = rd_b;
      PIO_OFS_PORT_C: rdata_nxt = rd_c;
      default:        rdata_nxt = PIO_RD_NONE; // Control byte has no readback
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      host_rdata_r  <= PIO_RD_NONE;
      host_rvalid_r <= 1'b0;
    end else if (clk_en) begin
      host_rvalid_r <= host_req.rd;
      if (host_req.rd) begin
        host_rdata_r <= rdata_nxt;
      end
    end
  end

endmodule
`default_nettype wire

/* inc/pio_pkg.sv */
// Package: register map, control byte layout and reset values of the parallel I/O port
package pio_pkg;

  localparam int          PIO_NUM_LINES   = 24;
  localparam logic [1:0]  PIO_OFS_PORT_A  = 2'h0;
  localparam logic [1:0]  PIO_OFS_PORT_B  = 2'h1;
  localparam logic [1:0]  PIO_OFS_PORT_C  = 2'h2;
  localparam logic [1:0]  PIO_OFS_CTRL    = 2'h3;

  // Control byte field positions
  localparam int          PIO_BIT_MODE_SET   = 7;
  localparam int          PIO_BIT_GRP1_HI    = 6;
  localparam int          PIO_BIT_GRP1_LO    = 5;
  localparam int          PIO_BIT_DIR_A      = 4;
  localparam int          PIO_BIT_DIR_CU     = 3;
  localparam int          PIO_BIT_GRP2       = 2;
  localparam int          PIO_BIT_DIR_B      = 1;
  localparam int          PIO_BIT_DIR_CL     = 0;

  localparam int          PIO_HALF_W         = 4;
  localparam logic [7:0]  PIO_DATA_RESET     = 8'h00;
  localparam logic [7:0]  PIO_RD_NONE        = 8'h00;

  // Group modes
  typedef enum logic [1:0] {
    PIO_MODE_BASIC,
    PIO_MODE_STROBED,
    PIO_MODE_BIDIR
  } pio_mode_e;

  // Direction set: one bit is input when set
  typedef struct packed {
    logic dir_a;
    logic upper_half_dir;
    logic dir_b;
    logic lower_half_dir;
  } pio_dir_s;

  localparam pio_dir_s    PIO_DIR_RESET = '{dir_a: 1'b1, upper_half_dir: 1'b1,
                                            dir_b: 1'b1, lower_half_dir: 1'b1};

  // Host access bundle
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [1:0] addr;
    logic [7:0] wdata;
  } pio_req_s;

endpackage

/* testbench/pio_field.sv */
// Field side model: external devices on the 24 port lines
`timescale 1ns/1ps
`default_nettype none
module pio_field (
  input  wire logic [23:0] drv,    // Block drive values
  input  wire logic [23:0] oe,     // Block output enables
  input  wire logic [23:0] ext,    // Field device levels
  input  wire logic [23:0] ext_en, // Field device drives line
  output logic      [23:0] pin     // Resolved line levels
);
  // Undriven lines fall to the pull-down level, never to a stale value
  assign pin = (oe & drv) | (~oe & ext_en & ext);
endmodule
`default_nettype wire

/* testbench/pio_props.sv */
// Checker: port-level properties of the parallel I/O port
`timescale 1ns/1ps
`default_nettype none
module pio_props
  import pio_pkg::*;
#(
  parameter bit EMULATION = 1'b1   // Variant that offers basic mode only
)
(
  input  wire logic       clock,         // System clock
  input  wire logic       reset,         // Synchronous reset, active high
  input  wire logic       clk_en,        // Clock enable
  input  wire pio_req_s   host_req,      // Host request
  input  wire logic [7:0] host_rdata_r,  // Read data
  input  wire logic       host_rvalid_r, // Read data valid
  input  wire logic [7:0] port_a_in,     // Port A pin levels
  input  wire logic [7:0] port_b_in,     // Port B pin levels
  input  wire logic [7:0] port_c_in,     // Port C pin levels
  input  wire logic [7:0] port_a_out_r,  // Port A drive value
  input  wire logic [7:0] port_a_oe_r,   // Port A output enable
  input  wire logic [7:0] port_b_out_r,  // Port B drive value
  input  wire logic [7:0] port_b_oe_r,   // Port B output enable
  input  wire logic [7:0] port_c_out_r,  // Port C drive value
  input  wire logic [7:0] port_c_oe_r,   // Port C output enable
  input  wire pio_mode_e  grp1_mode_r,   // First group mode
  input  wire pio_mode_e  grp2_mode_r    // Second group mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire [7:0]  wd = host_req.wdata;
  wire        ctl = clk_en && host_req.wr && host_req.addr == PIO_OFS_CTRL;
  // Pin enables lag the accepted byte by one edge, hence the two-cycle look-back
  wire        ok = ctl && wd[7] && !(EMULATION && (wd[6] || wd[5] || wd[2]));
  wire [23:0] oe_all = {port_a_oe_r, port_b_oe_r, port_c_oe_r};
  a_reset_all_in: assert property (disable iff (1'b0) reset |=> oe_all == 24'h000000)
    else $error("lines driven after reset");
  a_read_answer: assert property (clk_en && host_req.rd |=> host_rvalid_r)
    else $error("read not answered");
  a_ctrl_ignored: assert property (ctl && !wd[7] |=> ##1 oe_all == $past(oe_all))
    else $error("control byte without mode set acted");
  a_dir_apply: assert property (ok |=> ##1 port_a_oe_r == {8{~$past(wd[4], 2)}}
    && port_b_oe_r == {8{~$past(wd[1], 2)}}) else $error("port direction wrong");
  a_half_split: assert property (ok |=> ##1 port_c_oe_r == {{4{~$past(wd[3], 2)}}, {4{~$past(wd[0], 2)}}})
    else $error("port C halves wrong");
  a_clear_latch: assert property (ok |=> ##1 {port_a_out_r, port_b_out_r, port_c_out_r} == 24'h000000)
    else $error("latches not cleared");
  a_live_input: assert property (clk_en && host_req.rd && host_req.addr == PIO_OFS_PORT_A
    && port_a_oe_r == 8'h00 && !$past(host_req.wr) |=> host_rdata_r == $past(port_a_in))
    else $error("input read not live");
  a_mode_basic: assert property (EMULATION && ctl |=> ##1 grp1_mode_r == PIO_MODE_BASIC
    && grp2_mode_r == PIO_MODE_BASIC) else $error("non-basic mode taken");
  cover property (ok);
  cover property (ctl && !wd[7]);
  cover property (host_rvalid_r && oe_all != 24'h000000);
endmodule
bind pio_top pio_props #(.EMULATION(EMULATION)) i_pio_props (.clock, .reset, .clk_en, .host_req,
  .host_rdata_r, .host_rvalid_r, .port_a_in, .port_b_in, .port_c_in, .port_a_out_r, .port_a_oe_r,
  .port_b_out_r, .port_b_oe_r, .port_c_out_r, .port_c_oe_r, .grp1_mode_r, .grp2_mode_r);
`default_nettype wire

/* testbench/pio_top_bench.sv */
// Testbench: self-checking run of the parallel I/O port
`timescale 1ns/1ps
`default_nettype none
module pio_top_bench
  import pio_pkg::*;
();
  logic        clock, reset, clk_en, rvalid;
  pio_req_s    req;
  logic [7:0]  rdata, a_o, a_e, b_o, b_e, c_o, c_e, ctl, bad[4], lat[3], q[$];
  logic [23:0] pin, ext, en;
  logic [31:0] s = 32'h00001EF9;
  int          failures, checked;
  pio_mode_e   m1, m2;
  pio_top i_pio_top (.clock, .reset, .clk_en, .host_req(req), .host_rdata_r(rdata), .host_rvalid_r(rvalid),
    .port_a_in(pin[23:16]), .port_b_in(pin[15:8]), .port_c_in(pin[7:0]), .port_a_out_r(a_o),
    .port_a_oe_r(a_e), .port_b_out_r(b_o), .port_b_oe_r(b_e), .port_c_out_r(c_o), .port_c_oe_r(c_e),
    .grp1_mode_r(m1), .grp2_mode_r(m2));
  pio_field i_pio_field (.drv({a_o, b_o, c_o}), .oe({a_e, b_e, c_e}), .ext, .ext_en(en), .pin);
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Output bits read the latch, input bits the line level
  function automatic logic [7:0] ex(int a);
    logic [7:0] om;
    om = a == 0 ? {8{~ctl[4]}} : a == 1 ? {8{~ctl[1]}} : {{4{~ctl[3]}}, {4{~ctl[0]}}};
    return (om & lat[a]) | (~om & ext[23-8*a -: 8] & en[23-8*a -: 8]);
  endfunction
  task automatic check(logic [7:0] seen, logic [7:0] want);
    checked++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic op(logic r, logic w, logic [1:0] a, logic [7:0] d);
    @(posedge clock);
    #1;
    req = '{r, w, a, d};
  endtask
  task automatic idle(int n);
    repeat (n) op(0, 0, 0, 8'h00);
  endtask
  // Expectation uses the levels that stand at the edge taking the read
  task automatic rd(logic [1:0] a);
    op(1, 0, a, 8'h00);
    q.push_back(a == 3 ? 8'h00 : ex(a));
  endtask
  always @(negedge clock)
    if (rvalid === 1'b1) check(rdata, q.pop_front());
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  initial begin
    reset = 1;
    clk_en = 1;
    req = '0;
    ext = xs();
    en = xs();
    ctl = 8'h9B;
    lat = '{default: 8'h00};
    bad = '{8'h1B, 8'hDB, 8'hBB, 8'h9F};
    repeat (16) @(posedge clock);
    #1;
    reset = 0;
    check(a_e | b_e | c_e, 8'h00);
    for (int a = 0; a < 3; a++) rd(a);
    for (int i = 15; i >= 0; i--) begin
      ctl = {1'b1, 2'b00, i[3:2], 1'b0, i[1:0]};
      lat = '{default: 8'h00};
      op(0, 1, PIO_OFS_CTRL, ctl);
      idle(2);
      check(a_e, {8{~ctl[4]}});
      check(c_e, {{4{~ctl[3]}}, {4{~ctl[0]}}});
      check(b_e, {8{~ctl[1]}});
      rd(0);
      for (int a = 0; a < 3; a++) begin
        lat[a] = xs();
        op(0, 1, a, lat[a]);
        rd(a);
      end
      idle(1);
      check(a_o, lat[0]);
      check(b_o, lat[1]);
      check(c_o, lat[2]);
      ext = xs();
      en = xs();
      for (int a = 0; a < 3; a++) rd(a);
    end
    foreach (bad[j]) begin
      op(0, 1, PIO_OFS_CTRL, bad[j]);
      idle(2);
      check(a_e & b_e & c_e, 8'hFF);
      check(8'({m1, m2}), 8'({PIO_MODE_BASIC, PIO_MODE_BASIC}));
      rd(0);
    end
    // Frozen clock enable: control, write and read must all be lost
    idle(2);
    clk_en = 0;
    op(0, 1, PIO_OFS_CTRL, 8'h9B);
    op(0, 1, PIO_OFS_PORT_A, ~lat[0]);
    op(1, 0, PIO_OFS_PORT_A, 8'h00);
    op(0, 0, 0, 8'h00);
    clk_en = 1;
    idle(1);
    check(a_e & b_e & c_e, 8'hFF);
    rd(0);
    rd(3);
    idle(2);
    reset = 1;
    idle(2);
    reset = 0;
    check(a_e | b_e | c_e, 8'h00);
    check(a_o | b_o | c_o, 8'h00);
    ctl = 8'h9B;
    lat = '{default: 8'h00};
    for (int a = 0; a < 3; a++) rd(a);
    idle(3);
    check(8'(q.size()), 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
